// ===== verilog/gax_pkg.sv
// gax_pkg: shared constants, register map and carrier types of the pin and aux converter bank
package gax_pkg;

   // ----------------------------------------
   // widths
   // ----------------------------------------
   localparam int PIN_COUNT = 8;
   localparam int DATA_W    = 8;
   localparam int ADDR_W    = 8;

   // ----------------------------------------
   // register offsets and reset values
   // ----------------------------------------
   localparam logic [ADDR_W-1:0] ADDR_PIN_DIR   = 8'h13;
   localparam logic [ADDR_W-1:0] ADDR_PIN_DATA  = 8'h14;
   localparam logic [ADDR_W-1:0] ADDR_AUX_SETUP = 8'h15;
   localparam logic [ADDR_W-1:0] ADDR_AUX_MUX   = 8'h16;

   localparam logic [DATA_W-1:0] RST_PIN_DIR    = 8'h00;
   localparam logic [DATA_W-1:0] RST_PIN_DATA   = 8'h00;
   localparam logic [DATA_W-1:0] RST_AUX_SETUP  = 8'h00;
   localparam logic [DATA_W-1:0] RST_AUX_MUX    = 8'h01;
   localparam logic [DATA_W-1:0] READ_UNMAPPED  = 8'h00;

   // ----------------------------------------
   // field positions
   // ----------------------------------------
   localparam int RATE_MSB = 7;
   localparam int RATE_LSB = 6;
   localparam int REF_MSB  = 5;
   localparam int REF_LSB  = 3;
   localparam int GAIN_MSB = 2;
   localparam int GAIN_LSB = 0;
   localparam int MUXP_MSB = 7;
   localparam int MUXP_LSB = 4;
   localparam int MUXN_MSB = 3;
   localparam int MUXN_LSB = 0;

   // ----------------------------------------
   // field codes
   // ----------------------------------------
   localparam logic [2:0] REF_INTERNAL = 3'h0;
   localparam logic [2:0] REF_PAIR_01  = 3'h1;
   localparam logic [2:0] REF_PAIR_23  = 3'h2;
   localparam logic [2:0] REF_PAIR_45  = 3'h3;
   localparam logic [2:0] REF_SUPPLY   = 3'h4;
   localparam logic [2:0] GAIN_UNLISTED = 3'h6;
   localparam logic [3:0] MUX_AIN_LAST = 4'h9;
   localparam logic [3:0] MUX_COMMON   = 4'hA;
   localparam logic [3:0] MUX_TEMP     = 4'hB;
   localparam logic [3:0] MUX_AVDD     = 4'hC;
   localparam logic [3:0] MUX_DVDD     = 4'hD;
   localparam logic [3:0] MUX_TEST_SIGNAL_DAC     = 4'hE;
   localparam logic [3:0] MUX_OPEN     = 4'hF;

   // ----------------------------------------
   // carrier types
   // ----------------------------------------
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic              wr;
      logic              rd;
   } gax_bus_req_t;

   typedef struct packed {
      logic [DATA_W-1:0] rdata;
      logic              rvalid;
   } gax_bus_rsp_t;

   typedef struct packed {
      logic [PIN_COUNT-1:0] level;
      logic [PIN_COUNT-1:0] oe;
   } gax_pin_drive_t;

   typedef struct packed {
      logic [9:0] rate_sps;
      logic [7:0] gain;
      logic [2:0] ref_sel;
      logic       ref_reserved;
      logic       gain_reserved;
      logic [3:0] pos_sel;
      logic [3:0] neg_sel;
      logic       pos_is_ain;
      logic       neg_is_ain;
   } gax_aux_cfg_t;

   typedef struct packed {
      logic [DATA_W-1:0] dir;
      logic [DATA_W-1:0] data;
      logic [DATA_W-1:0] setup;
      logic [DATA_W-1:0] mux;
      logic [DATA_W-1:0] rdata;
      logic              rvalid;
   } gax_regs_state_t;

   localparam gax_aux_cfg_t AUX_CFG_RST = '{rate_sps: 10'h00A, gain: 8'h01,
      ref_sel: REF_INTERNAL, ref_reserved: 1'b0, gain_reserved: 1'b0,
      pos_sel: 4'h0, neg_sel: 4'h1, pos_is_ain: 1'b1, neg_is_ain: 1'b1};

   // ----------------------------------------
   // decode functions
   // ----------------------------------------
   function automatic logic [9:0] gax_rate_sps(input logic [1:0] code);
      unique case (code)
         2'h0: gax_rate_sps = 10'h00A;
         2'h1: gax_rate_sps = 10'h064;
         2'h2: gax_rate_sps = 10'h190;
         default: gax_rate_sps = 10'h320;
      endcase
   endfunction : gax_rate_sps

   // unlisted code reads back as gain zero so it is visible downstream
   function automatic logic [7:0] gax_gain(input logic [2:0] code);
      if (code == GAIN_UNLISTED) begin
         gax_gain = 8'h00;
      end else if (code == 3'h7) begin
         gax_gain = 8'h80;
      end else begin
         gax_gain = 8'(8'h01 << code);
      end
   endfunction : gax_gain

   function automatic logic gax_ref_reserved(input logic [2:0] code);
      gax_ref_reserved = (code > REF_SUPPLY);
   endfunction : gax_ref_reserved

   function automatic logic gax_is_ain(input logic [3:0] code);
      gax_is_ain = (code <= MUX_AIN_LAST);
   endfunction : gax_is_ain

endpackage : gax_pkg

// ===== verilog/gax_sync3.sv
// gax_sync3: three-stage pin synchroniser with agreement filter
module gax_sync3 #(
   parameter int W = 8
) (
   input  wire logic         clk_sys,
   input  wire logic         arst_n,
   input  wire logic         ce,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] q;
   } gax_sync_state_t;

   gax_sync_state_t st_reg;
   gax_sync_state_t st_next;

   // stage one feeds stage two only; the filter looks at stages two and three
   always_comb begin
      st_next    = st_reg;
      st_next.s1 = d;
      st_next.s2 = st_reg.s1;
      st_next.s3 = st_reg.s2;
      for (int i = 0; i < W; i++) begin
         if (st_reg.s2[i] == st_reg.s3[i]) begin
            st_next.q[i] = st_reg.s3[i];
         end
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         st_reg <= '0;
      end else if (ce) begin
         st_reg <= st_next;
      end
   end

   assign q = st_reg.q;
endmodule : gax_sync3

// ===== verilog/gax_aux_decode.sv
// gax_aux_decode: registered decode of the aux converter setup and input select
module gax_aux_decode
   import gax_pkg::*;
(
   input  wire logic                  clk_sys,
   input  wire logic                  arst_n,
   input  wire logic                  ce,
   input  wire logic [7:0]            setup,
   input  wire logic [7:0]            mux,
   output gax_pkg::gax_aux_cfg_t      cfg
);
   gax_aux_cfg_t st_reg;
   gax_aux_cfg_t st_next;

   always_comb begin
      st_next.rate_sps      = gax_rate_sps(setup[RATE_MSB:RATE_LSB]);
      st_next.ref_sel       = setup[REF_MSB:REF_LSB];
      st_next.ref_reserved  = gax_ref_reserved(setup[REF_MSB:REF_LSB]);
      st_next.gain          = gax_gain(setup[GAIN_MSB:GAIN_LSB]);
      st_next.gain_reserved = (setup[GAIN_MSB:GAIN_LSB] == GAIN_UNLISTED);
      st_next.pos_sel       = mux[MUXP_MSB:MUXP_LSB];
      st_next.neg_sel       = mux[MUXN_MSB:MUXN_LSB];
      st_next.pos_is_ain    = gax_is_ain(mux[MUXP_MSB:MUXP_LSB]);
      st_next.neg_is_ain    = gax_is_ain(mux[MUXN_MSB:MUXN_LSB]);
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         st_reg <= AUX_CFG_RST;
      end else if (ce) begin
         st_reg <= st_next;
      end
   end

   assign cfg = st_reg;
endmodule : gax_aux_decode

// ===== verilog/gax_regs.sv
// gax_regs: pin data/direction and aux converter configuration register bank
// What this block does
// - data bit n drives pin n level
// - output-configured pins read back as zero
// - input pins: write only stores the bit
// - pin data at 14h, resets to 00h
// - rate field 7:6 selects 10/100/400/800
// - reference field 5:3 decode, 101/110/111 reserved
// - gain field 2:0 gives 1..32, 128
// - aux setup at 15h, resets to 00h
// - positive select field 7:4 decode
// - negative select field 3:0 same codes
// - aux input select at 16h, resets 01h
// - direction bit 0 output, 1 input
module gax_regs
   import gax_pkg::*;
(
   input  wire logic                     clk_sys,
   input  wire logic                     arst_n,
   input  wire logic                     ce,
   input  wire gax_pkg::gax_bus_req_t    bus_req,
   output gax_pkg::gax_bus_rsp_t         bus_rsp,
   input  wire logic [PIN_COUNT-1:0]     pin_in,
   output gax_pkg::gax_pin_drive_t       pin_drive,
   output gax_pkg::gax_aux_cfg_t         aux_cfg
);

   // ----------------------------------------
   // state
   // ----------------------------------------
   gax_regs_state_t      st_reg;
   gax_regs_state_t      st_next;
   logic [PIN_COUNT-1:0] pin_level_sync;
   logic                 wr_hit;
   logic                 rd_hit;

   // ----------------------------------------
   // pin input synchroniser
   // ----------------------------------------
   gax_sync3 #(
      .W (PIN_COUNT)
   ) u_pin_sync (
      .clk_sys (clk_sys),
      .arst_n  (arst_n),
      .ce      (ce),
      .d       (pin_in),
      .q       (pin_level_sync)
   );

   // ----------------------------------------
   // aux converter setting decode
   // ----------------------------------------
   gax_aux_decode u_aux_decode (
      .clk_sys (clk_sys),
      .arst_n  (arst_n),
      .ce      (ce),
      .setup   (st_reg.setup),
      .mux     (st_reg.mux),
      .cfg     (aux_cfg)
   );

   // ----------------------------------------
   // register update and read path
   // ----------------------------------------
   // a strobe seen while ce is low is dropped, not held over
   assign wr_hit = bus_req.wr;
   assign rd_hit = bus_req.rd;

   always_comb begin
      st_next        = st_reg;
      st_next.rvalid = rd_hit;
      st_next.rdata  = '0;
      if (wr_hit) begin
         unique case (bus_req.addr)
            ADDR_PIN_DIR: begin
               st_next.dir = bus_req.wdata;
            end
            ADDR_PIN_DATA: begin
               // stored for every bit; only output bits reach a pin
               st_next.data = bus_req.wdata;
            end
            ADDR_AUX_SETUP: begin
               st_next.setup = bus_req.wdata;
            end
            ADDR_AUX_MUX: begin
               st_next.mux = bus_req.wdata;
            end
            default: begin
               st_next.dir = st_reg.dir;
            end
         endcase
      end
      if (rd_hit) begin
         unique case (bus_req.addr)
            ADDR_PIN_DIR: begin
               st_next.rdata = st_reg.dir;
            end
            ADDR_PIN_DATA: begin
               // output bits read zero, input bits show the filtered pin level
               st_next.rdata = pin_level_sync & st_reg.dir;
            end
            ADDR_AUX_SETUP: begin
               st_next.rdata = st_reg.setup;
            end
            ADDR_AUX_MUX: begin
               st_next.rdata = st_reg.mux;
            end
            default: begin
               st_next.rdata = READ_UNMAPPED;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         st_reg.dir    <= RST_PIN_DIR;
         st_reg.data   <= RST_PIN_DATA;
         st_reg.setup  <= RST_AUX_SETUP;
         st_reg.mux    <= RST_AUX_MUX;
         st_reg.rdata  <= '0;
         st_reg.rvalid <= 1'b0;
      end else if (ce) begin
         st_reg <= st_next;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign bus_rsp.rdata  = st_reg.rdata;
   assign bus_rsp.rvalid = st_reg.rvalid;
   assign pin_drive.level = st_reg.data & ~st_reg.dir;
   assign pin_drive.oe    = ~st_reg.dir;

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!arst_n);

   sequence wr_to_s(logic [ADDR_W-1:0] a);
      ce && bus_req.wr && bus_req.addr == a;
   endsequence

   sequence rd_of_s(logic [ADDR_W-1:0] a);
      ce && bus_req.rd && bus_req.addr == a;
   endsequence

   sequence settle_s;
      ce [*2];
   endsequence

   sequence no_wr_s(logic [ADDR_W-1:0] a);
      !(ce && bus_req.wr && bus_req.addr == a);
   endsequence

   // written level appears on output pins in the next cycle
   pin_level_follows_a: assert property (
      wr_to_s(ADDR_PIN_DATA) |=>
         pin_drive.level == ($past(bus_req.wdata) & ~st_reg.dir))
      else $error("pin level does not follow written data");

   // a data read never shows a bit that was an output at read time
   out_reads_zero_a: assert property (
      rd_of_s(ADDR_PIN_DATA) |=>
         bus_rsp.rvalid && (bus_rsp.rdata & ~$past(st_reg.dir)) == 8'h00)
      else $error("output pin bit read back nonzero");

   // writing data while all pins are inputs leaves every pin undriven
   in_write_quiet_a: assert property (
      wr_to_s(ADDR_PIN_DATA) ##0 st_reg.dir == 8'hFF |=>
         pin_drive.oe == 8'h00 && st_reg.data == $past(bus_req.wdata))
      else $error("input pin write disturbed the pin");

   // input bits read back the filtered pin level
   data_readback_a: assert property (
      rd_of_s(ADDR_PIN_DATA) |=>
         bus_rsp.rdata == ($past(pin_level_sync) & $past(st_reg.dir)))
      else $error("pin data read value wrong");

   // registers hold their reset values on release
   reset_values_a: assert property (
      $rose(arst_n) |->
         st_reg.data == 8'h00 && st_reg.setup == 8'h00 && st_reg.mux == 8'h01
         && st_reg.dir == 8'h00 && aux_cfg.rate_sps == 10'd10 && aux_cfg.gain == 8'd1)
      else $error("reset value wrong after release");

   // rate field reaches the decoded rate two active cycles after the write
   rate_decode_a: assert property (
      wr_to_s(ADDR_AUX_SETUP) ##1 settle_s |->
         aux_cfg.rate_sps == gax_rate_sps($past(bus_req.wdata[RATE_MSB:RATE_LSB], 2)))
      else $error("aux rate decode wrong");

   // reserved reference codes are flagged
   ref_decode_a: assert property (
      wr_to_s(ADDR_AUX_SETUP) ##1 settle_s |->
         aux_cfg.ref_sel == $past(bus_req.wdata[REF_MSB:REF_LSB], 2)
         && aux_cfg.ref_reserved == ($past(bus_req.wdata[REF_MSB:REF_LSB], 2) > 3'h4))
      else $error("aux reference decode wrong");

   // gain code decodes to its factor
   gain_decode_a: assert property (
      wr_to_s(ADDR_AUX_SETUP) ##1 settle_s |->
         aux_cfg.gain == gax_gain($past(bus_req.wdata[GAIN_MSB:GAIN_LSB], 2)))
      else $error("aux gain decode wrong");

   // setup written then read back unchanged
   setup_readback_a: assert property (
      wr_to_s(ADDR_AUX_SETUP) ##1 rd_of_s(ADDR_AUX_SETUP) |=>
         bus_rsp.rdata == $past(bus_req.wdata, 2))
      else $error("aux setup readback mismatch");

   // positive select decode
   pos_select_a: assert property (
      wr_to_s(ADDR_AUX_MUX) ##1 settle_s |->
         aux_cfg.pos_sel == $past(bus_req.wdata[MUXP_MSB:MUXP_LSB], 2)
         && aux_cfg.pos_is_ain == ($past(bus_req.wdata[MUXP_MSB:MUXP_LSB], 2) <= 4'h9))
      else $error("positive select decode wrong");

   // negative select decode uses the same codes
   neg_select_a: assert property (
      wr_to_s(ADDR_AUX_MUX) ##1 settle_s |->
         aux_cfg.neg_sel == $past(bus_req.wdata[MUXN_MSB:MUXN_LSB], 2)
         && aux_cfg.neg_is_ain == ($past(bus_req.wdata[MUXN_MSB:MUXN_LSB], 2) <= 4'h9))
      else $error("negative select decode wrong");

   // input select written then read back unchanged
   mux_readback_a: assert property (
      wr_to_s(ADDR_AUX_MUX) ##1 rd_of_s(ADDR_AUX_MUX) |=>
         bus_rsp.rdata == $past(bus_req.wdata, 2))
      else $error("aux input select readback mismatch");

   // direction write sets drive enables one cycle later
   dir_drive_a: assert property (
      wr_to_s(ADDR_PIN_DIR) |=> pin_drive.oe == ~$past(bus_req.wdata))
      else $error("direction write did not set drive enables");

   // unmapped read answers zero, and read data stand one cycle only
   unmapped_read_a: assert property (
      ce && bus_req.rd && !(bus_req.addr inside {[8'h13:8'h16]}) |=>
         bus_rsp.rvalid && bus_rsp.rdata == 8'h00)
      else $error("unmapped read not zero");

   read_one_cycle_a: assert property (
      ce && !bus_req.rd |=> !bus_rsp.rvalid && bus_rsp.rdata == 8'h00)
      else $error("read data stood outside its cycle");

   // ----------------------------------------
   // holding and freezing
   // ----------------------------------------
   // pins move only on a register write
   level_hold_a: assert property (
      !(ce && bus_req.wr) |=>
         $stable(pin_drive.level) && $stable(pin_drive.oe))
      else $error("pin drive changed without a write");

   // an undriven pin never carries a stored level
   undriven_low_a: assert property (
      (pin_drive.level & ~pin_drive.oe) == 8'h00)
      else $error("level shown on an input pin");

   // pin data changes only by its own write
   data_hold_a: assert property (
      no_wr_s(ADDR_PIN_DATA) |=> $stable(st_reg.data))
      else $error("pin data changed without a write");

   dir_hold_a: assert property (
      no_wr_s(ADDR_PIN_DIR) |=> $stable(st_reg.dir))
      else $error("direction changed without a write");

   setup_hold_a: assert property (
      no_wr_s(ADDR_AUX_SETUP) |=> $stable(st_reg.setup))
      else $error("aux setup changed without a write");

   mux_hold_a: assert property (
      no_wr_s(ADDR_AUX_MUX) |=> $stable(st_reg.mux))
      else $error("aux input select changed without a write");

   // writes outside the map leave every register alone
   unmapped_write_a: assert property (
      ce && bus_req.wr && !(bus_req.addr inside {[8'h13:8'h16]}) |=>
         $stable(st_reg.dir) && $stable(st_reg.data)
         && $stable(st_reg.setup) && $stable(st_reg.mux))
      else $error("unmapped write changed a register");

   // low clock enable freezes registers, decode and filter
   freeze_hold_a: assert property (
      !ce |=> $stable(st_reg) && $stable(aux_cfg) && $stable(pin_level_sync))
      else $error("state moved while the clock enable was low");

   // direction reads back as held
   dir_readback_a: assert property (
      rd_of_s(ADDR_PIN_DIR) |=> bus_rsp.rdata == $past(st_reg.dir))
      else $error("direction readback wrong");

   // ----------------------------------------
   // decoded aux settings
   // ----------------------------------------
   // decoded rate is always one of the four listed rates
   rate_set_a: assert property (
      aux_cfg.rate_sps inside {10'h00A, 10'h064, 10'h190, 10'h320})
      else $error("aux rate outside the listed set");

   // decoded gain is a listed factor unless the code is flagged
   gain_set_a: assert property (
      aux_cfg.gain_reserved
      || aux_cfg.gain inside {8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h80})
      else $error("aux gain outside the listed set");

   // decoded fields follow the registers one active cycle later
   ref_follow_a: assert property (
      ce |=> aux_cfg.ref_sel == $past(st_reg.setup[REF_MSB:REF_LSB]))
      else $error("aux reference does not follow setup");

   pos_follow_a: assert property (
      ce |=> aux_cfg.pos_sel == $past(st_reg.mux[MUXP_MSB:MUXP_LSB])
         && aux_cfg.pos_is_ain == ($past(st_reg.mux[MUXP_MSB:MUXP_LSB]) < 4'hA))
      else $error("positive select does not follow register");

   neg_follow_a: assert property (
      ce |=> aux_cfg.neg_sel == $past(st_reg.mux[MUXN_MSB:MUXN_LSB])
         && aux_cfg.neg_is_ain == ($past(st_reg.mux[MUXN_MSB:MUXN_LSB]) < 4'hA))
      else $error("negative select does not follow register");

endmodule : gax_regs

// ===== verif/gax_host_model.sv
// gax_host_model: bus master model standing in for the host controller
module gax_host_model
   import gax_pkg::*;
(
   input  wire logic                  clk_sys,
   output gax_pkg::gax_bus_req_t      bus_req,
   input  wire gax_pkg::gax_bus_rsp_t bus_rsp
);
   timeunit 1ns;
   timeprecision 1ns;

   initial begin
      bus_req = '{addr: 8'h00, wdata: 8'h00, wr: 1'b0, rd: 1'b0};
   end

   // released lines show the inverse of the last value, so a design that
   // samples them outside the strobe cycle picks up garbage, not a copy
   task automatic release_bus();
      bus_req <= '{addr: ~bus_req.addr, wdata: ~bus_req.wdata, wr: 1'b0, rd: 1'b0};
   endtask : release_bus

   // callers keep reserved reference and unlisted gain codes out of setup
   task automatic write_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge clk_sys);
      bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk_sys);
      release_bus();
   endtask : write_reg

   // read data stand only in the cycle after the read edge
   task automatic read_reg(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d,
                           output logic v);
      @(posedge clk_sys);
      bus_req <= '{addr: a, wdata: bus_req.wdata, wr: 1'b0, rd: 1'b1};
      @(posedge clk_sys);
      release_bus();
      @(negedge clk_sys);
      d = bus_rsp.rdata;
      v = bus_rsp.rvalid;
   endtask : read_reg

   // write, then read the same place with the read strobe right behind it
   task automatic write_read(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                             output logic [DATA_W-1:0] q, output logic v);
      @(posedge clk_sys);
      bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk_sys);
      bus_req <= '{addr: a, wdata: d, wr: 1'b0, rd: 1'b1};
      @(posedge clk_sys);
      release_bus();
      @(negedge clk_sys);
      q = bus_rsp.rdata;
      v = bus_rsp.rvalid;
   endtask : write_read

endmodule : gax_host_model

// ===== verif/gax_regs_tb.sv
// gax_regs_tb: self-checking bench for the pin data and aux converter register bank
module gax_regs_tb import gax_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;

   typedef struct packed {
      logic [7:0] setup;
      logic [9:0] rate;
      logic [7:0] gain;
   } gax_row_t;

   logic                 clk_sys;
   logic                 arst_n;
   logic                 ce;
   gax_bus_req_t         bus_req;
   gax_bus_rsp_t         bus_rsp;
   logic [PIN_COUNT-1:0] pin_in;
   gax_pin_drive_t       pin_drive;
   gax_aux_cfg_t         aux_cfg;
   int                   err_total;
   int                   n_tests;
   logic [DATA_W-1:0]    rd_data;
   logic                 rd_valid;

   // ----------------------------------------
   // setup rows: every rate, listed reference and listed gain code
   // ----------------------------------------
   gax_row_t rows [8] = '{'{8'h00, 10'h00A, 8'h01}, '{8'h41, 10'h064, 8'h02},
                          '{8'h8A, 10'h190, 8'h04}, '{8'hD3, 10'h320, 8'h08},
                          '{8'h1C, 10'h00A, 8'h10}, '{8'h65, 10'h064, 8'h20},
                          '{8'h87, 10'h190, 8'h80}, '{8'hE3, 10'h320, 8'h08}};

   gax_regs dut_u (
      .clk_sys   (clk_sys),
      .arst_n    (arst_n),
      .ce        (ce),
      .bus_req   (bus_req),
      .bus_rsp   (bus_rsp),
      .pin_in    (pin_in),
      .pin_drive (pin_drive),
      .aux_cfg   (aux_cfg)
   );

   gax_host_model host_u (
      .clk_sys (clk_sys),
      .bus_req (bus_req),
      .bus_rsp (bus_rsp)
   );

   initial begin
      clk_sys = 1'b0;
      forever begin
         #50 clk_sys = ~clk_sys;
      end
   end

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected at %0t ns: seen %0h expected %0h", $time, seen, exp);
      end
   endtask : chk

   task automatic rd_expect(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
      host_u.read_reg(a, rd_data, rd_valid);
      chk(rd_data, exp);
      chk(rd_valid, 1'b1);
   endtask : rd_expect

   task automatic wr_rd_expect(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      host_u.write_read(a, d, rd_data, rd_valid);
      chk(rd_data, d);
      chk(rd_valid, 1'b1);
   endtask : wr_rd_expect

   task automatic do_reset();
      @(posedge clk_sys);
      arst_n <= 1'b0;
      repeat (5) @(posedge clk_sys);
      arst_n <= 1'b1;
   endtask : do_reset

   task automatic check_defaults();
      @(negedge clk_sys);
      chk(aux_cfg.rate_sps, 10'h00A);
      chk(aux_cfg.gain, 8'h01);
      chk(aux_cfg.ref_sel, 3'h0);
      chk({aux_cfg.pos_sel, aux_cfg.neg_sel}, 8'h01);
      chk(pin_drive.oe, 8'hFF);
      chk(pin_drive.level, 8'h00);
      rd_expect(ADDR_PIN_DIR, 8'h00);
      rd_expect(ADDR_PIN_DATA, 8'h00);
      rd_expect(ADDR_AUX_SETUP, 8'h00);
      rd_expect(ADDR_AUX_MUX, 8'h01);
   endtask : check_defaults

   task automatic close_out();
      $display("comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : close_out

   // the sequence needs well under 2000 cycles; ten times that means a hang
   initial begin
      repeat (20000) @(posedge clk_sys);
      err_total++;
      close_out();
   end

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      err_total = 0;
      n_tests = 0;
      arst_n = 1'b0;
      ce = 1'b1;
      pin_in = 8'h00;
      do_reset();
      check_defaults();
      $display("test reset defaults done");

      // all 16 select codes on both sides, setup rows repeat twice
      for (int i = 0; i < 16; i++) begin
         wr_rd_expect(ADDR_AUX_SETUP, rows[i % 8].setup);
         wr_rd_expect(ADDR_AUX_MUX, {4'(i), 4'(15 - i)});
         chk(aux_cfg.rate_sps, rows[i % 8].rate);
         chk(aux_cfg.gain, rows[i % 8].gain);
         chk({aux_cfg.gain_reserved, aux_cfg.ref_reserved, aux_cfg.ref_sel},
             {2'b00, rows[i % 8].setup[5:3]});
         chk({aux_cfg.pos_sel, aux_cfg.neg_sel}, {4'(i), 4'(15 - i)});
         chk({aux_cfg.pos_is_ain, aux_cfg.neg_is_ain}, {i <= 9, (15 - i) <= 9});
      end
      $display("test aux table done");

      // low nibble input, high nibble output
      host_u.write_reg(ADDR_PIN_DATA, 8'hA5);
      host_u.write_reg(ADDR_PIN_DIR, 8'h0F);
      @(negedge clk_sys);
      chk(pin_drive.oe, 8'hF0);
      chk(pin_drive.level, 8'hA0);
      @(posedge clk_sys);
      pin_in <= 8'h3C;
      repeat (6) @(posedge clk_sys);
      rd_expect(ADDR_PIN_DATA, 8'h0C);
      host_u.write_reg(ADDR_PIN_DATA, 8'h5A);
      @(negedge clk_sys);
      chk(pin_drive.oe, 8'hF0);
      chk(pin_drive.level, 8'h50);
      rd_expect(ADDR_PIN_DATA, 8'h0C);
      host_u.write_reg(ADDR_PIN_DIR, 8'h00);
      @(negedge clk_sys);
      chk(pin_drive.oe, 8'hFF);
      chk(pin_drive.level, 8'h5A);
      rd_expect(ADDR_PIN_DATA, 8'h00);
      host_u.write_reg(ADDR_PIN_DIR, 8'hFF);
      host_u.write_reg(ADDR_PIN_DATA, 8'hC3);
      @(negedge clk_sys);
      chk(pin_drive.oe, 8'h00);
      rd_expect(ADDR_PIN_DATA, 8'h3C);
      host_u.write_reg(ADDR_PIN_DIR, 8'h00);
      @(negedge clk_sys);
      chk(pin_drive.level, 8'hC3);
      $display("test pins done");

      // unmapped place and a strobe while the clock enable is low
      host_u.write_reg(8'h20, 8'hFF);
      rd_expect(8'h20, 8'h00);
      rd_expect(ADDR_AUX_SETUP, 8'hE3);
      rd_expect(ADDR_AUX_MUX, 8'hF0);
      @(posedge clk_sys);
      ce <= 1'b0;
      host_u.write_reg(ADDR_AUX_SETUP, 8'h41);
      @(posedge clk_sys);
      ce <= 1'b1;
      rd_expect(ADDR_AUX_SETUP, 8'hE3);
      $display("test unmapped and enable done");

      // second reset in mid-run restores every default
      do_reset();
      check_defaults();
      $display("test mid-run reset done");
      close_out();
   end

endmodule : gax_regs_tb
